// *** bench/iss_core_model.sv ***
/* Core model: services the presented request with a vector fetch pulse.
   Assumes a registered request; the gap sets prompt or slow service. */
`timescale 1ns/1ps
module iss_core_model (
    input wire logic mclk, // Bus clock
    input wire logic nrst, // Reset, active low
    input wire logic cpu_imask, // Global mask
    input wire logic cpu_irq_req, // Request
    input wire logic [4:0] cpu_irq_num, // Presented number
    input wire logic [3:0] svc_gap, // Cycles between services
    output logic cpu_ack, // Vector fetch pulse
    output logic [4:0] cpu_ack_num // Serviced number
);
    logic [3:0] wait_r;
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            wait_r <= 4'h0;
            cpu_ack <= 1'b0;
            cpu_ack_num <= 5'h00;
        end else begin
            cpu_ack <= 1'b0;
            if (wait_r != 4'h0) begin
                wait_r <= wait_r - 4'h1;
            end else if (cpu_irq_req && !cpu_imask) begin
                cpu_ack <= 1'b1;
                cpu_ack_num <= cpu_irq_num;
                wait_r <= svc_gap;
            end
        end
    end
endmodule

// *** bench/iss_props.sv ***
/* Checker of the iss_top ports: core request, reset and register bus relations.
   Assumes it is bound into iss_top; one clock domain. */
`timescale 1ns/1ps
module iss_props (
    input wire logic mclk, // Bus clock
    input wire logic nrst, // Reset, active low
    input wire iss_pkg::iss_axi_req_t axi_req, // Bus request
    input wire iss_pkg::iss_axi_rsp_t axi_rsp, // Bus answer
    input wire logic irq_pin, // External pin
    input wire logic [7:0] keypad_pins, // Keypad pins
    input wire logic [11:0] periph_req, // Peripheral requests
    input wire logic cpu_imask, // Global mask
    input wire logic cpu_ack, // Vector fetch
    input wire logic cpu_irq_req, // Core request
    input wire logic [4:0] cpu_irq_num, // Presented number
    input wire logic irq // Block interrupt
);
    import iss_pkg::*;
    default clocking @(posedge mclk); endclocking
    default disable iff (!nrst);
    // **********************
    // Cause sequences
    // **********************
    sequence pin_cause_s;
        (!irq_pin && !cpu_imask) ##1 (!cpu_imask && !cpu_ack) ##1 !cpu_imask;
    endsequence
    sequence key_cause_s;
        (keypad_pins != 8'hff && !cpu_imask) ##1 (!cpu_imask && !cpu_ack) ##1 !cpu_imask;
    endsequence
    pin_first_a: assert property (pin_cause_s |-> ##1 cpu_irq_req && cpu_irq_num == 5'h01)
        else $error("pin request not presented first");
    key_req_a: assert property (key_cause_s |-> ##1 cpu_irq_req)
        else $error("keypad request not presented");
    mask_blk_a: assert property (cpu_imask [*2] |=> !cpu_irq_req)
        else $error("request passed the global mask");
    periph_prio_a: assert property ((periph_req[0] && irq_pin && !cpu_imask) [*2] |=>
        cpu_irq_req && cpu_irq_num inside {5'h01, 5'h02})
        else $error("wrong number for flag two");
    rst_clear_a: assert property ($rose(nrst) |-> !cpu_irq_req && !irq && !axi_rsp.bvalid && !axi_rsp.rvalid)
        else $error("outputs not cleared by reset");
    rdata_hi_a: assert property (axi_rsp.rvalid |-> axi_rsp.rdata[31:8] == 24'h00_0000)
        else $error("upper read bits not zero");
    ar_answer_a: assert property (axi_req.arvalid && axi_rsp.arready |=> axi_rsp.rvalid)
        else $error("read not answered");
    w_answer_a: assert property (axi_req.awvalid && axi_rsp.awready && axi_req.wvalid && axi_rsp.wready
        |-> ##[1:2] axi_rsp.bvalid)
        else $error("write not answered");
    b_busy_a: assert property (axi_rsp.bvalid && !axi_req.bready |=> axi_rsp.bvalid)
        else $error("write answer dropped before taken");
endmodule

bind iss_top iss_props i_props (.mclk, .nrst, .axi_req, .axi_rsp, .irq_pin, .keypad_pins, .periph_req,
    .cpu_imask, .cpu_ack, .cpu_irq_req, .cpu_irq_num, .irq);

// *** bench/testbench.sv ***
/* Testbench of iss_top: register views, core link, converter and tick.
   Assumes the design package and defines on the include path. */
`timescale 1ns/1ps
`include "iss_defines.svh"
module testbench;
    import iss_pkg::*;
    logic mclk;
    logic nrst;
    iss_axi_req_t axi_req;
    iss_axi_rsp_t axi_rsp;
    logic irq_pin;
    logic [7:0] keypad_pins;
    logic [11:0] periph_req;
    logic conv_complete;
    logic cpu_imask;
    logic cpu_ack;
    logic [4:0] cpu_ack_num;
    logic cpu_irq_req;
    logic [4:0] cpu_irq_num;
    logic irq;
    logic [3:0] svc_gap;
    logic [31:0] cyc;
    logic [31:0] d;
    logic [31:0] t0;
    logic [31:0] t1;
    logic [1:0] r;
    int error_cnt;
    int checks_done;

    iss_top i_dut (.mclk, .nrst, .axi_req, .axi_rsp, .irq_pin, .keypad_pins, .periph_req, .conv_complete,
        .cpu_imask, .cpu_ack, .cpu_ack_num, .cpu_irq_req, .cpu_irq_num, .irq);
    iss_core_model i_core (.mclk, .nrst, .cpu_imask, .cpu_irq_req, .cpu_irq_num, .svc_gap, .cpu_ack,
        .cpu_ack_num);

    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end
    always @(posedge mclk) cyc <= cyc + 32'h0000_0001;

    // **********************
    // Checking and bus tasks
    // **********************
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic close_out;
        if (error_cnt == 0 && checks_done > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task automatic hang;
        chk(32'h0000_0000, 32'h0000_0001);
        close_out;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] resp);
        int n = 0;
        @(posedge mclk);
        axi_req.awvalid <= 1'b1;
        axi_req.awaddr <= a;
        axi_req.wvalid <= 1'b1;
        axi_req.wdata <= v;
        axi_req.bready <= 1'b1;
        do begin
            @(posedge mclk);
            n++;
            if (axi_req.awvalid && axi_rsp.awready) axi_req.awvalid <= 1'b0;
            if (axi_req.wvalid && axi_rsp.wready) axi_req.wvalid <= 1'b0;
        end while (!axi_rsp.bvalid && n < 50);
        if (!axi_rsp.bvalid) hang;
        resp = axi_rsp.bresp;
        axi_req.bready <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] resp);
        int n = 0;
        @(posedge mclk);
        axi_req.arvalid <= 1'b1;
        axi_req.araddr <= a;
        axi_req.rready <= 1'b1;
        do begin
            @(posedge mclk);
            n++;
            if (axi_req.arvalid && axi_rsp.arready) axi_req.arvalid <= 1'b0;
        end while (!axi_rsp.rvalid && n < 50);
        if (!axi_rsp.rvalid) hang;
        v = axi_rsp.rdata;
        resp = axi_rsp.rresp;
        axi_req.rready <= 1'b0;
    endtask
    task automatic rc(input logic [7:0] a, input logic [7:0] e);
        logic [31:0] v;
        logic [1:0] resp;
        rd(a, v, resp);
        chk(v, {24'h00_0000, e});
    endtask
    // Unmask until the core has serviced everything, then mask again
    task automatic drain;
        int n = 0;
        cpu_imask <= 1'b0;
        do begin
            @(posedge mclk);
            n++;
        end while ((cpu_irq_req || n < 6) && n < 300);
        if (cpu_irq_req) hang;
        cpu_imask <= 1'b1;
    endtask
    // Wait for a tick event, note its cycle and clear it
    task automatic tk(output logic [31:0] t);
        int n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (!irq && n < 40000);
        if (!irq) hang;
        t = cyc;
        wr(`ISS_OFF_IRQ_STAT, 32'h0000_0002, r);
    endtask

    // **********************
    // Main sequence
    // **********************
    initial begin
        int i;
        nrst = 1'b0;
        axi_req = '0;
        axi_req.wstrb = 4'hf;
        irq_pin = 1'b1;
        keypad_pins = 8'hff;
        periph_req = 12'h000;
        conv_complete = 1'b0;
        cpu_imask = 1'b1;
        svc_gap = 4'h3;
        cyc = 32'h0000_0000;
        error_cnt = 0;
        checks_done = 0;
        repeat (3) @(posedge mclk);
        nrst <= 1'b1;
        for (i = 0; i < 7; i++) rc(8'((i + 4) % 7 * 4), 8'h00);
        rd(8'h1C, d, r);
        chk(32'(r), 32'(`ISS_RESP_SLVERR));
        chk(d, 32'h0000_0000);
        for (i = 0; i < 12; i++) begin
            periph_req <= 12'h001 << i;
            rc(`ISS_OFF_VIEW_LOW, 8'(32'h8 << i));
            rc(`ISS_OFF_VIEW_MID, 8'((32'h8 << i) >> 8));
        end
        periph_req <= 12'h000;
        wr(`ISS_OFF_VIEW_MID, 32'h0000_00ff, r);
        chk(32'(r), 32'(`ISS_RESP_OKAY));
        rc(`ISS_OFF_VIEW_MID, 8'h00);
        irq_pin <= 1'b0;
        keypad_pins <= 8'hdf;
        @(posedge mclk);
        irq_pin <= 1'b1;
        keypad_pins <= 8'hff;
        rc(`ISS_OFF_VIEW_LOW, 8'h04);
        rc(`ISS_OFF_VIEW_MID, 8'h80);
        chk(32'(cpu_irq_req), 32'h0000_0000);
        drain;
        rc(`ISS_OFF_VIEW_LOW, 8'h00);
        rc(`ISS_OFF_VIEW_MID, 8'h00);
        cpu_imask <= 1'b0;
        irq_pin <= 1'b0;
        keypad_pins <= 8'hfe;
        repeat (2) @(posedge mclk);
        irq_pin <= 1'b1;
        keypad_pins <= 8'hff;
        drain;
        svc_gap <= 4'h9;
        wr(`ISS_OFF_CTRL, 32'h0000_0001, r);
        conv_complete <= 1'b1;
        @(posedge mclk);
        conv_complete <= 1'b0;
        rc(`ISS_OFF_VIEW_HIGH, 8'h01);
        rd(`ISS_OFF_SRC_STAT, d, r);
        chk(d & 32'h0000_0001, 32'h0000_0000);
        chk(32'(irq), 32'h0000_0000);
        wr(`ISS_OFF_IRQ_MASK, 32'h0000_0004, r);
        chk(32'(irq), 32'h0000_0001);
        wr(`ISS_OFF_IRQ_STAT, 32'h0000_0004, r);
        chk(32'(irq), 32'h0000_0000);
        drain;
        rc(`ISS_OFF_VIEW_HIGH, 8'h00);
        wr(`ISS_OFF_CTRL, 32'h0000_0000, r);
        conv_complete <= 1'b1;
        @(posedge mclk);
        conv_complete <= 1'b0;
        rd(`ISS_OFF_SRC_STAT, d, r);
        chk(d & 32'h0000_0001, 32'h0000_0001);
        rc(`ISS_OFF_VIEW_HIGH, 8'h00);
        wr(`ISS_OFF_CTRL, 32'h0000_0040, r);
        rd(`ISS_OFF_SRC_STAT, d, r);
        chk(d & 32'h0000_0001, 32'h0000_0000);
        wr(`ISS_OFF_IRQ_MASK, 32'h0000_0002, r);
        for (i = 0; i < 6; i++) begin
            wr(`ISS_OFF_CTRL, 32'h2 | (i << 2), r);
            tk(t0);
            tk(t0);
            tk(t1);
            chk(t1 - t0, 32'h1 << (4 + 2 * i));
        end
        rc(`ISS_OFF_VIEW_HIGH, 8'h02);
        wr(`ISS_OFF_CTRL, 32'h0000_0036, r);
        rd(`ISS_OFF_SRC_STAT, d, r);
        chk(d & 32'h0000_0002, 32'h0000_0000);
        rc(`ISS_OFF_VIEW_HIGH, 8'h00);
        rc(`ISS_OFF_CTRL, 8'h16);
        nrst <= 1'b0;
        @(posedge mclk);
        nrst <= 1'b1;
        rc(`ISS_OFF_CTRL, 8'h00);
        rc(`ISS_OFF_IRQ_MASK, 8'h00);
        close_out;
    end
endmodule

// *** common/iss_defines.svh ***
/*
 * Offsets, field positions, flag numbers and timing figures of the
 * interrupt source status block.
 * Assumes a 10 MHz bus clock and an AXI4-Lite register port with byte addresses.
 */
`ifndef ISS_DEFINES_SVH
`define ISS_DEFINES_SVH

// Register byte offsets
`define ISS_OFF_VIEW_LOW 8'h00
`define ISS_OFF_VIEW_MID 8'h04
`define ISS_OFF_VIEW_HIGH 8'h08
`define ISS_OFF_CTRL 8'h0C
`define ISS_OFF_SRC_STAT 8'h10
`define ISS_OFF_IRQ_STAT 8'h14
`define ISS_OFF_IRQ_MASK 8'h18

// Control register fields
`define ISS_CTRL_CONV_EN 0
`define ISS_CTRL_TICK_EN 1
`define ISS_CTRL_RATE_LO 2
`define ISS_CTRL_TICK_ACKNOWLEDGE 5
`define ISS_CTRL_CONV_CLR 6

// Source status fields
`define ISS_SRC_CONV_DONE 0
`define ISS_SRC_TICK_ROLL 1

// Interrupt status events
`define ISS_EV_NEW_PEND 0
`define ISS_EV_TICK 1
`define ISS_EV_CONV 2

// Flag numbers with a latch of their own
`define ISS_FLAG_PIN 5'h01
`define ISS_FLAG_KEYPAD 5'h0E
`define ISS_FLAG_CONV 5'h0F

// Tick counter chain: tap index is base plus twice the rate select
`define ISS_TICK_TAP_BASE 5'h03
`define ISS_TICK_WIDTH 18

// AXI responses
`define ISS_RESP_OKAY 2'h0
`define ISS_RESP_SLVERR 2'h2

`endif

// *** common/iss_pkg.sv ***
/*
 * Types of the interrupt source status block: bus carriers and the state record.
 * Assumes iss_defines.svh is on the include path.
 */
`include "iss_defines.svh"

package iss_pkg;

    typedef struct packed {
        logic awvalid;
        logic [7:0] awaddr;
        logic wvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bready;
        logic arvalid;
        logic [7:0] araddr;
        logic rready;
    } iss_axi_req_t;

    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } iss_axi_rsp_t;

    typedef struct packed {
        logic aw_have;
        logic [7:0] aw_addr;
        logic w_have;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic conv_irq_enable;
        logic tick_irq_enable;
        logic [2:0] tick_rate_select;
        logic conv_done_flag;
        logic tick_rollover_flag;
        logic pin_latch;
        logic keypad_latch;
        logic conv_pending;
        logic [`ISS_TICK_WIDTH-1:0] tick_count;
        logic tap_prev;
        logic [15:0] source_pending_flags;
        logic [2:0] irq_status;
        logic [2:0] irq_mask;
        logic irq;
        logic cpu_irq_req;
        logic [4:0] cpu_irq_num;
    } iss_state_t;

endpackage

// *** src/iss_top.sv ***
/*
 * Interrupt source status block: collects maskable requests, mirrors them
 * into read-only status flags, runs the periodic tick unit and presents the
 * highest priority request to the core.
 * Assumes all inputs synchronous to mclk and peripheral request lines held
 * high while their source flag and enable are both set.
 */
// Implementation choices: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`include "iss_defines.svh"

module iss_top (
    input wire logic mclk,                              // Bus clock, 10 MHz
    input wire logic nrst,                              // Synchronous reset, active low
    input wire iss_pkg::iss_axi_req_t axi_req,          // AXI4-Lite master to slave
    output iss_pkg::iss_axi_rsp_t axi_rsp,              // AXI4-Lite slave to master
    input wire logic irq_pin,                           // External request pin
    input wire logic [7:0] keypad_pins,                 // Keypad request pins
    input wire logic [11:0] periph_req,                 // Requests for flags 2 to 13
    input wire logic conv_complete,                     // One-cycle pulse per conversion
    input wire logic cpu_imask,                         // Core global mask bit
    input wire logic cpu_ack,                           // Core vector fetch pulse
    input wire logic [4:0] cpu_ack_num,                 // Flag number being serviced
    output logic cpu_irq_req,                           // Request to the core
    output logic [4:0] cpu_irq_num,                     // Flag number presented
    output logic irq                                    // Block interrupt, level
);
    import iss_pkg::*;

    iss_state_t st_r;
    iss_state_t st_nxt;

    // ************************************************************
    // Combinational helpers
    // ************************************************************

    logic wr_fire;
    logic wr_ok;
    logic rd_fire;
    logic [4:0] tap_idx;
    logic tap_now;
    logic tick_event;
    logic tick_acknowledge_write;
    logic conv_clr_write;
    logic [15:0] pend_vec;
    logic [15:0] avail_vec;
    logic [2:0] events;
    logic [31:0] rd_word;
    logic rd_ok;
    logic [4:0] pick_num;
    logic pick_any;

    always_comb begin
        wr_fire = st_r.aw_have && st_r.w_have && !st_r.bvalid;
        wr_ok = 1'b0;
        tick_acknowledge_write = 1'b0;
        conv_clr_write = 1'b0;
        if (wr_fire) begin
            unique case (st_r.aw_addr)
                `ISS_OFF_VIEW_LOW, `ISS_OFF_VIEW_MID, `ISS_OFF_VIEW_HIGH, `ISS_OFF_SRC_STAT: begin
                    wr_ok = 1'b1;
                end
                `ISS_OFF_CTRL: begin
                    wr_ok = 1'b1;
                    tick_acknowledge_write = st_r.w_strb[0] && st_r.w_data[`ISS_CTRL_TICK_ACKNOWLEDGE];
                    conv_clr_write = st_r.w_strb[0] && st_r.w_data[`ISS_CTRL_CONV_CLR];
                end
                `ISS_OFF_IRQ_STAT, `ISS_OFF_IRQ_MASK: begin
                    wr_ok = 1'b1;
                end
                default: begin
                    wr_ok = 1'b0;
                end
            endcase
        end
        rd_fire = axi_req.arvalid && !st_r.rvalid;

        // Tick tap selection and falling edge of the tapped bit
        tap_idx = `ISS_TICK_TAP_BASE + {1'b0, st_r.tick_rate_select, 1'b0};
        tap_now = st_r.tick_count[tap_idx];
        tick_event = st_r.tap_prev && !tap_now;

        // Pending requests by flag, bit n-1 holds flag n
        pend_vec[0] = st_r.pin_latch;
        pend_vec[12:1] = periph_req;
        pend_vec[13] = st_r.keypad_latch;
        pend_vec[14] = st_r.conv_pending;
        pend_vec[15] = st_r.tick_rollover_flag && st_r.tick_irq_enable;

        // Priority pick over the registered flags
        avail_vec = cpu_imask ? 16'h0000 : st_r.source_pending_flags;
        pick_any = |avail_vec;
        pick_num = 5'h00;
        for (int i = 15; i >= 0; i--) begin
            if (avail_vec[i]) begin
                pick_num = 5'(i + 1);
            end
        end

        events = 3'h0;
        events[`ISS_EV_NEW_PEND] = |(pend_vec & ~st_r.source_pending_flags);
        events[`ISS_EV_TICK] = tick_event;
        events[`ISS_EV_CONV] = conv_complete;

        // Read data mux
        rd_ok = 1'b1;
        rd_word = 32'h0000_0000;
        unique case (axi_req.araddr)
            `ISS_OFF_VIEW_LOW: begin
                rd_word[7:2] = st_r.source_pending_flags[5:0];
            end
            `ISS_OFF_VIEW_MID: begin
                rd_word[7:0] = st_r.source_pending_flags[13:6];
            end
            `ISS_OFF_VIEW_HIGH: begin
                rd_word[1:0] = st_r.source_pending_flags[15:14];
            end
            `ISS_OFF_CTRL: begin
                rd_word[`ISS_CTRL_CONV_EN] = st_r.conv_irq_enable;
                rd_word[`ISS_CTRL_TICK_EN] = st_r.tick_irq_enable;
                rd_word[`ISS_CTRL_RATE_LO +: 3] = st_r.tick_rate_select;
            end
            `ISS_OFF_SRC_STAT: begin
                rd_word[`ISS_SRC_CONV_DONE] = st_r.conv_done_flag;
                rd_word[`ISS_SRC_TICK_ROLL] = st_r.tick_rollover_flag;
            end
            `ISS_OFF_IRQ_STAT: begin
                rd_word[2:0] = st_r.irq_status;
            end
            `ISS_OFF_IRQ_MASK: begin
                rd_word[2:0] = st_r.irq_mask;
            end
            default: begin
                rd_ok = 1'b0;
            end
        endcase
    end

    // ************************************************************
    // Next state
    // ************************************************************

    always_comb begin
        st_nxt = st_r;

        // Write address and data channels, taken in either order
        if (axi_req.awvalid && !st_r.aw_have) begin
            st_nxt.aw_have = 1'b1;
            st_nxt.aw_addr = axi_req.awaddr;
        end
        if (axi_req.wvalid && !st_r.w_have) begin
            st_nxt.w_have = 1'b1;
            st_nxt.w_data = axi_req.wdata;
            st_nxt.w_strb = axi_req.wstrb;
        end
        if (wr_fire) begin
            st_nxt.aw_have = 1'b0;
            st_nxt.w_have = 1'b0;
            st_nxt.bvalid = 1'b1;
            st_nxt.bresp = wr_ok ? `ISS_RESP_OKAY : `ISS_RESP_SLVERR;
        end
        if (st_r.bvalid && axi_req.bready) begin
            st_nxt.bvalid = 1'b0;
        end

        // Read channel
        if (rd_fire) begin
            st_nxt.rvalid = 1'b1;
            st_nxt.rdata = rd_word;
            st_nxt.rresp = rd_ok ? `ISS_RESP_OKAY : `ISS_RESP_SLVERR;
        end
        if (st_r.rvalid && axi_req.rready) begin
            st_nxt.rvalid = 1'b0;
        end

        // Register writes; view registers and source status ignore data
        if (wr_fire && st_r.w_strb[0]) begin
            unique case (st_r.aw_addr)
                `ISS_OFF_CTRL: begin
                    st_nxt.conv_irq_enable = st_r.w_data[`ISS_CTRL_CONV_EN];
                    st_nxt.tick_irq_enable = st_r.w_data[`ISS_CTRL_TICK_EN];
                    st_nxt.tick_rate_select = st_r.w_data[`ISS_CTRL_RATE_LO +: 3];
                end
                `ISS_OFF_IRQ_MASK: begin
                    st_nxt.irq_mask = st_r.w_data[2:0];
                end
                default: begin
                end
            endcase
        end

        // Pin and keypad latches: cleared on service, a low level wins
        if (cpu_ack && cpu_ack_num == `ISS_FLAG_PIN) begin
            st_nxt.pin_latch = 1'b0;
        end
        if (!irq_pin) begin
            st_nxt.pin_latch = 1'b1;
        end
        if (cpu_ack && cpu_ack_num == `ISS_FLAG_KEYPAD) begin
            st_nxt.keypad_latch = 1'b0;
        end
        if (keypad_pins != 8'hFF) begin
            st_nxt.keypad_latch = 1'b1;
        end

        // Converter completion: request when enabled, done flag otherwise
        if (cpu_ack && cpu_ack_num == `ISS_FLAG_CONV) begin
            st_nxt.conv_pending = 1'b0;
        end
        if (conv_clr_write) begin
            st_nxt.conv_done_flag = 1'b0;
        end
        if (conv_complete) begin
            if (st_r.conv_irq_enable) begin
                st_nxt.conv_pending = 1'b1;
            end else begin
                st_nxt.conv_done_flag = 1'b1;
            end
        end

        // Tick unit
        st_nxt.tick_count = st_r.tick_count + `ISS_TICK_WIDTH'(1);
        st_nxt.tap_prev = tap_now;
        if (tick_acknowledge_write) begin
            st_nxt.tick_rollover_flag = 1'b0;
        end
        if (tick_event) begin
            st_nxt.tick_rollover_flag = 1'b1;
        end

        // Mirror of pending requests, read-only
        st_nxt.source_pending_flags = pend_vec;

        // Sticky events, write one to clear, new events win
        if (wr_fire && st_r.aw_addr == `ISS_OFF_IRQ_STAT && st_r.w_strb[0]) begin
            st_nxt.irq_status = st_r.irq_status & ~st_r.w_data[2:0];
        end
        st_nxt.irq_status = st_nxt.irq_status | events;
        st_nxt.irq = |(st_nxt.irq_status & st_nxt.irq_mask);

        // Core request
        st_nxt.cpu_irq_req = pick_any;
        st_nxt.cpu_irq_num = pick_num;

        if (!nrst) begin
            st_nxt = '0;
        end
    end

    // ************************************************************
    // State register
    // ************************************************************

    always_ff @(posedge mclk) begin
        st_r <= st_nxt;
    end

    assign axi_rsp.awready = !st_r.aw_have;
    assign axi_rsp.wready = !st_r.w_have;
    assign axi_rsp.bvalid = st_r.bvalid;
    assign axi_rsp.bresp = st_r.bresp;
    assign axi_rsp.arready = !st_r.rvalid;
    assign axi_rsp.rvalid = st_r.rvalid;
    assign axi_rsp.rdata = st_r.rdata;
    assign axi_rsp.rresp = st_r.rresp;
    assign cpu_irq_req = st_r.cpu_irq_req;
    assign cpu_irq_num = st_r.cpu_irq_num;
    assign irq = st_r.irq;

endmodule
